// ==== rtl/tx_event_pkg.sv ====
package tx_event_pkg;

  // register byte offsets on the avalon slave
  localparam logic [5:0] CTRL_OFS = 6'h00;
  localparam logic [5:0] IRQ_STATUS_OFS = 6'h04;
  localparam logic [5:0] IRQ_MASK_OFS = 6'h08;
  localparam logic [5:0] LAST_RECORD_OFS = 6'h0C;
  localparam logic [5:0] LAST_SIZE_OFS = 6'h10;
  localparam logic [5:0] STAMP_NOW_OFS = 6'h14;

  // control register fields
  localparam int CTRL_WIDE_TAG_BIT = 0;
  localparam int CTRL_NO_RETX_BIT = 1;
  localparam int CTRL_PRESCALE_LSB = 4;
  localparam int PRESCALE_W = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // interrupt status bits
  localparam int IRQ_W = 2;
  localparam int IRQ_STORED_BIT = 0;
  localparam int IRQ_CANCEL_BIT = 1;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

  // record word fields
  localparam int REC_TAG_LO_LSB = 24;
  localparam int REC_KIND_LSB = 22;
  localparam int REC_FD_BIT = 21;
  localparam int REC_BRS_BIT = 20;
  localparam int REC_DLC_LSB = 16;
  localparam int REC_TAG_HI_LSB = 8;
  localparam int REC_CAPTURE_VALID_BIT = 4;
  localparam int STAMP_W = 16;

  typedef enum logic [1:0] {
    KIND_RSVD0 = 2'h0,
    KIND_VALID = 2'h1,
    KIND_SENT_DESPITE_CANCEL = 2'h2,
    KIND_RSVD3 = 2'h3
  } event_kind_t;

  // classic frames never carry more than this
  localparam logic [6:0] CLASSIC_MAX_BYTES = 7'h08;

endpackage : tx_event_pkg

// ==== rtl/stamp_if.sv ====
`timescale 1ns/1ps
interface stamp_if;
  import tx_event_pkg::*;
  logic [PRESCALE_W-1:0] prescale;
  logic start;
  logic [STAMP_W-1:0] now;
  logic [STAMP_W-1:0] captured;

  modport ctrl (output prescale, output start, input now, input captured);
  modport timer (input prescale, input start, output now, output captured);
endinterface : stamp_if

// ==== rtl/stamp_timer.sv ====
`timescale 1ns/1ps
module stamp_timer (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  stamp_if.timer st
);
  import tx_event_pkg::*;

  logic [PRESCALE_W-1:0] div_cnt;
  logic tick;
  logic [STAMP_W-1:0] count;
  logic [STAMP_W-1:0] capture;

  // compare with >= so a smaller prescale takes effect at once
  // instead of letting the divider run round all sixteen counts
  assign tick = (div_cnt >= st.prescale);

  // prescaler: one tick every prescale+1 clocks
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      div_cnt <= '0;
    end else if (tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // free running counter, wraps silently
  // prescaled tick resolution
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      count <= '0;
    end else if (tick) begin
      count <= count + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      capture <= '0;
    end else if (st.start) begin
      capture <= count;
    end
  end

  assign st.now = count;
  assign st.captured = capture;
endmodule : stamp_timer

// ==== rtl/can_tx_event_record_fmt.sv ====
`timescale 1ns/1ps
module can_tx_event_record_fmt (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // avalon-mm slave
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic irq_out,
  // bus engine side
  input wire logic tx_start_in,
  input wire logic tx_done_in,
  input wire logic [15:0] tx_msg_tag_in,
  input wire logic fd_frame_flag_in,
  input wire logic rate_switch_flag_in,
  input wire logic [3:0] dlc_in,
  input wire logic cancel_req_in,
  input wire logic event_store_request_in,
  // record towards the message ram queue
  output logic [31:0] record_out,
  output logic record_valid_out,
  output logic [6:0] payload_bytes_out
);
  import tx_event_pkg::*;

  stamp_if st ();

  stamp_timer u_timer (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .st(st)
  );

  logic [31:0] ctrl;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic wide_tag_enable;
  logic no_retransmit_setting;
  logic [PRESCALE_W-1:0] stamp_prescale;
  logic bus_req;
  logic wr_take;
  logic store_now;
  event_kind_t next_kind;
  logic [31:0] next_record;
  logic [31:0] next_readdata;
  logic [IRQ_W-1:0] set_bits;
  logic [IRQ_W-1:0] clr_bits;

  // length code to payload bytes, used for record and register
  function automatic logic [6:0] dlc_to_bytes(input logic [3:0] dlc, input logic fd);
    logic [6:0] n;
    n = {3'h0, dlc};
    if (dlc > 4'h8) begin
      if (!fd) begin
        n = CLASSIC_MAX_BYTES;
      end else begin
        unique case (dlc)
          4'h9: n = 7'h0C;
          4'hA: n = 7'h10;
          4'hB: n = 7'h14;
          4'hC: n = 7'h18;
          4'hD: n = 7'h20;
          4'hE: n = 7'h30;
          default: n = 7'h40;
        endcase
      end
    end
    return n;
  endfunction : dlc_to_bytes

  // byte-lane merge for register writes
  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_be

  assign wide_tag_enable = ctrl[CTRL_WIDE_TAG_BIT];
  assign no_retransmit_setting = ctrl[CTRL_NO_RETX_BIT];
  assign stamp_prescale = ctrl[CTRL_PRESCALE_LSB +: PRESCALE_W];
  assign st.prescale = stamp_prescale;
  assign st.start = tx_start_in;

  // only frames that asked for a record
  assign store_now = tx_done_in && event_store_request_in;

  // event kind from cancel request and retransmit mode
  always_comb begin
    if (no_retransmit_setting || cancel_req_in) begin
      next_kind = KIND_SENT_DESPITE_CANCEL;
    end else begin
      next_kind = KIND_VALID;
    end
  end

  // assemble the word from the current completion inputs; without wide tags the low half is the stamp captured at tx start
  always_comb begin
    next_record = 32'h0000_0000;
    next_record[REC_TAG_LO_LSB +: 8] = tx_msg_tag_in[7:0];
    next_record[REC_KIND_LSB +: 2] = next_kind;
    next_record[REC_FD_BIT] = fd_frame_flag_in;
    next_record[REC_BRS_BIT] = rate_switch_flag_in;
    next_record[REC_DLC_LSB +: 4] = dlc_in;
    if (wide_tag_enable) begin
      next_record[REC_TAG_HI_LSB +: 8] = tx_msg_tag_in[15:8];
      next_record[REC_CAPTURE_VALID_BIT] = 1'b0;
    end else begin
      next_record[STAMP_W-1:0] = st.captured;
    end
  end

  // record output: one word per completion that asked for a record, so order follows send order
  // single-cycle word
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      record_out <= 32'h0000_0000;
      record_valid_out <= 1'b0;
      payload_bytes_out <= 7'h00;
    end else begin
      record_valid_out <= store_now;
      if (store_now) begin
        record_out <= next_record;
        payload_bytes_out <= dlc_to_bytes(dlc_in, fd_frame_flag_in);
      end
    end
  end

  // avalon handshake: waitrequest drops one cycle after the request,
  // the write lands on the next edge, as it rises again; costs a cycle but keeps outputs registered
  assign bus_req = avs_read_in || avs_write_in;
  assign wr_take = avs_write_in && !avs_waitrequest_out;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      avs_waitrequest_out <= 1'b1;
    end else if (bus_req && avs_waitrequest_out) begin
      avs_waitrequest_out <= 1'b0;
    end else begin
      avs_waitrequest_out <= 1'b1;
    end
  end

  // read mux, unmapped reads return zero
  always_comb begin
    unique case (avs_address_in)
      CTRL_OFS: next_readdata = ctrl;
      IRQ_STATUS_OFS: next_readdata = {30'h0, irq_status};
      IRQ_MASK_OFS: next_readdata = {30'h0, irq_mask};
      LAST_RECORD_OFS: next_readdata = record_out;
      LAST_SIZE_OFS: next_readdata = {25'h0, payload_bytes_out};
      STAMP_NOW_OFS: next_readdata = {16'h0, st.now};
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && avs_waitrequest_out) begin
      avs_readdata_out <= next_readdata;
    end
  end

  // control register; only defined fields are kept
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ctrl <= CTRL_RESET;
    end else if (wr_take && avs_address_in == CTRL_OFS) begin
      ctrl <= merge_be(ctrl, avs_writedata_in, avs_byteenable_in)
              & {24'h0, 4'hF, 2'h0, 2'h3};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      irq_mask <= IRQ_RESET;
    end else if (wr_take && avs_address_in == IRQ_MASK_OFS && avs_byteenable_in[0]) begin
      irq_mask <= avs_writedata_in[IRQ_W-1:0];
    end
  end

  // sticky status, write one to clear; a new event wins over the clear
  always_comb begin
    set_bits = '0;
    set_bits[IRQ_STORED_BIT] = store_now;
    set_bits[IRQ_CANCEL_BIT] = store_now && (next_kind == KIND_SENT_DESPITE_CANCEL);
    clr_bits = '0;
    if (wr_take && avs_address_in == IRQ_STATUS_OFS && avs_byteenable_in[0]) begin
      clr_bits = avs_writedata_in[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      irq_status <= IRQ_RESET;
    end else begin
      irq_status <= (irq_status & ~clr_bits) | set_bits;
    end
  end

  // level interrupt, registered so it lags status by one cycle
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_status & irq_mask);
    end
  end

endmodule : can_tx_event_record_fmt

// ==== dv/rec_fmt_asserts.sv ====
`timescale 1ns/1ps
module rec_fmt_asserts (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic tx_done_in,
  input wire logic [15:0] tx_msg_tag_in,
  input wire logic fd_frame_flag_in,
  input wire logic rate_switch_flag_in,
  input wire logic [3:0] dlc_in,
  input wire logic cancel_req_in,
  input wire logic event_store_request_in,
  input wire logic [31:0] record_out,
  input wire logic record_valid_out,
  input wire logic [6:0] payload_bytes_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  logic take;
  // frame completion that asks for a record
  assign take = tx_done_in && event_store_request_in;
  // long fd sizes, kept apart from the design's own table
  function automatic logic [6:0] fd_bytes(input logic [3:0] d);
    logic [6:0] t [7] = '{7'h0C, 7'h10, 7'h14, 7'h18, 7'h20, 7'h30, 7'h40};
    return (d > 4'h8) ? t[d - 4'h9] : {3'h0, d};
  endfunction : fd_bytes
  a_store_one: assert property (take |=> record_valid_out)
    else $error("record missing");
  a_no_store: assert property (!take |=> !record_valid_out)
    else $error("stray record");
  a_tag_low: assert property (
    record_valid_out |-> record_out[31:24] == $past(tx_msg_tag_in[7:0]))
    else $error("tag byte wrong");
  a_fd_flag: assert property (
    record_valid_out |-> record_out[21] == $past(fd_frame_flag_in))
    else $error("format bit wrong");
  a_rate_flag: assert property (
    record_valid_out |-> record_out[20] == $past(rate_switch_flag_in))
    else $error("switch bit wrong");
  a_dlc_copy: assert property (
    record_valid_out |-> record_out[19:16] == $past(dlc_in))
    else $error("length code wrong");
  a_kind_cancel: assert property (
    record_valid_out && $past(cancel_req_in) |-> record_out[23:22] == 2'h2)
    else $error("kind not 10");
  a_kind_legal: assert property (
    record_valid_out |-> record_out[23] != record_out[22])
    else $error("reserved kind");
  a_classic_size: assert property (
    record_valid_out && !record_out[21] |-> payload_bytes_out ==
      ((record_out[19:16] > 4'h8) ? 7'h08 : {3'h0, record_out[19:16]}))
    else $error("classic size wrong");
  a_fd_size: assert property (
    record_valid_out && record_out[21] |-> payload_bytes_out == fd_bytes(record_out[19:16]))
    else $error("fd size wrong");
  a_word_hold: assert property (!record_valid_out |-> $stable(record_out))
    else $error("word changed alone");
  a_size_hold: assert property (!record_valid_out |-> $stable(payload_bytes_out))
    else $error("size changed alone");
endmodule : rec_fmt_asserts
bind can_tx_event_record_fmt rec_fmt_asserts rec_fmt_asserts_i (.clk_sys_in, .srst_in,
  .tx_done_in, .tx_msg_tag_in, .fd_frame_flag_in, .rate_switch_flag_in, .dlc_in,
  .cancel_req_in, .event_store_request_in, .record_out, .record_valid_out, .payload_bytes_out);

// ==== dv/can_engine_model.sv ====
`timescale 1ns/1ps
module can_engine_model (
  input wire logic clk_sys_in,
  output logic start_out,
  output logic done_out,
  output logic [24:0] fields_out
);
  // quiet until the bench sends a frame
  initial begin
    start_out = 1'b0;
    done_out = 1'b0;
    fields_out = '0;
  end
  // one frame: start pulse, air time, done pulse; frames strictly one after another
  task send(input logic [24:0] f, input int gap);
    start_out <= 1'b1;
    @(posedge clk_sys_in);
    start_out <= 1'b0;
    repeat (gap) @(posedge clk_sys_in);
    done_out <= 1'b1;
    fields_out <= f;
    @(posedge clk_sys_in);
    done_out <= 1'b0;
    // fields only count in the done cycle, so scramble them afterwards
    fields_out <= ~f;
  endtask : send
endmodule : can_engine_model

// ==== dv/test_can_tx_event_record_fmt.sv ====
`timescale 1ns/1ps
module test_can_tx_event_record_fmt;
  import tx_event_pkg::*;
  typedef struct {logic [31:0] rec; logic [31:0] mask; logic [6:0] bytes; int delta;} note_t;
  logic clk_sys_in = 1'b0, srst_in = 1'b1, rd = 1'b0, wr = 1'b0, wide = 1'b0, no_retx = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata, record, q;
  logic wait_req, irq, valid, tx_start, tx_done;
  logic [6:0] bytes;
  logic [24:0] f;
  logic [15:0] last_ts = 16'h0;
  logic [6:0] fd_sz [7] = '{7'h0C, 7'h10, 7'h14, 7'h18, 7'h20, 7'h30, 7'h40};
  note_t notes[$];
  note_t n;
  int error_cnt = 0, check_count = 0;
  always #20 clk_sys_in = ~clk_sys_in;
  can_engine_model can_engine_model_i (.clk_sys_in, .start_out(tx_start), .done_out(tx_done),
    .fields_out(f));
  can_tx_event_record_fmt can_tx_event_record_fmt_i (.clk_sys_in, .srst_in,
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req),
    .irq_out(irq), .tx_start_in(tx_start), .tx_done_in(tx_done), .tx_msg_tag_in(f[24:9]),
    .fd_frame_flag_in(f[8]), .rate_switch_flag_in(f[7]), .dlc_in(f[6:3]),
    .cancel_req_in(f[2]), .event_store_request_in(f[1]), .record_out(record),
    .record_valid_out(valid), .payload_bytes_out(bytes));
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t %s: %h vs %h", $time, what, seen, exp);
    end
  endtask : chk
  // hold the request until waitrequest is seen low, then a spare edge
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    @(posedge clk_sys_in);
    while (wait_req !== 1'b0) @(posedge clk_sys_in);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_sys_in);
  endtask : bus
  task ctrl(input logic [31:0] d);
    bus(1'b1, CTRL_OFS, d);
    wide = d[CTRL_WIDE_TAG_BIT];
    no_retx = d[CTRL_NO_RETX_BIT];
  endtask : ctrl
  // note the expected word, then let the engine send the frame
  task frame(input logic fd, input logic [3:0] dlc, input logic cancel, input logic st, int d);
    logic [15:0] tag;
    logic rate_switch_flag;
    note_t m;
    tag = 16'($urandom);
    rate_switch_flag = 1'($urandom);
    m.rec = {tag[7:0], (cancel | no_retx) ? 2'h2 : 2'h1, fd, rate_switch_flag, dlc,
      wide ? {tag[15:8], 8'h00} : 16'h0000};
    // pointer bits carry nothing, but the block drives them 0
    m.mask = wide ? 32'hFFFFFFFF : 32'hFFFF0000;
    m.bytes = (dlc <= 4'h8) ? {3'h0, dlc} : (fd ? fd_sz[dlc - 4'h9] : 7'h08);
    m.delta = d;
    if (st) notes.push_back(m);
    can_engine_model_i.send({tag, fd, rate_switch_flag, dlc, cancel, st, 1'b0}, 6);
  endtask : frame
  // scoreboard: each record against the oldest note
  always @(posedge clk_sys_in) begin
    if (valid === 1'b1) begin
      if (notes.size() == 0) chk(32'h1, 32'h0, "unexpected record");
      else begin
        n = notes.pop_front();
        chk(record & n.mask, n.rec, "record word");
        chk({25'h0, bytes}, {25'h0, n.bytes}, "payload");
        if (n.delta >= 0) chk({16'h0, record[15:0] - last_ts}, 32'(n.delta), "stamp");
        last_ts = record[15:0];
      end
    end
  end
  task wrap_up;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  // watchdog far beyond the few hundred cycles the run needs
  initial begin
    #200000;
    chk(32'h1, 32'h0, "timeout");
    wrap_up();
  end
  initial begin
    void'($urandom(83));
    repeat (6) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    @(posedge clk_sys_in);
    // every code in both formats, cancel on odd codes
    for (int i = 0; i < 32; i++) frame(i[4], i[3:0], i[0], 1'b1, -1);
    frame(1'b0, 4'h3, 1'b0, 1'b0, -1);
    ctrl(32'h2);
    frame(1'b1, 4'hF, 1'b0, 1'b1, -1);
    // starts 8 clocks apart: 2 ticks at prescale 3, 8 ticks at 0
    ctrl(32'h30);
    for (int i = 0; i < 3; i++) frame(1'b0, 4'h8, 1'b0, 1'b1, (i > 0) ? 2 : -1);
    ctrl(32'h0);
    for (int i = 0; i < 3; i++) frame(1'b1, 4'h9, 1'b0, 1'b1, (i > 0) ? 8 : -1);
    ctrl(32'h1);
    frame(1'b1, 4'hA, 1'b1, 1'b1, -1);
    frame(1'b0, 4'h2, 1'b0, 1'b1, -1);
    // interrupt raised, cleared, then masked
    bus(1'b1, IRQ_MASK_OFS, 32'h3);
    bus(1'b1, IRQ_STATUS_OFS, 32'h3);
    frame(1'b0, 4'h1, 1'b1, 1'b1, -1);
    repeat (3) @(posedge clk_sys_in);
    chk({31'h0, irq}, 32'h1, "irq raised");
    bus(1'b0, IRQ_STATUS_OFS, 32'h0);
    chk(q, 32'h3, "status");
    bus(1'b1, IRQ_STATUS_OFS, 32'h3);
    bus(1'b1, IRQ_MASK_OFS, 32'h0);
    frame(1'b0, 4'h1, 1'b0, 1'b1, -1);
    repeat (3) @(posedge clk_sys_in);
    chk({31'h0, irq}, 32'h0, "irq masked");
    bus(1'b0, 6'h3C, 32'h0);
    chk(q, 32'h0, "unmapped read");
    chk(32'(notes.size()), 32'h0, "records lost");
    wrap_up();
  end
endmodule : test_can_tx_event_record_fmt
